// ### hw/sflcu_pkg.sv
// constants shared by the serial frame check-value unit
package sflcu_pkg;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [7:0] LRC_PRESET = 8'h00;
  localparam logic [7:0] LRC_ONES = 8'hFF;
  localparam logic [7:0] LRC_ONE = 8'h01;
  localparam logic [7:0] ASCII_COLON = 8'h3A;
  localparam logic [7:0] ASCII_CR = 8'h0D;
  localparam logic [7:0] ASCII_LF = 8'h0A;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_A_LESS10 = 8'h37;
  localparam logic [3:0] NIB_NINE = 4'h9;
  localparam logic [2:0] SHIFT_LAST = 3'h7;
  localparam logic [1:0] TX_IDX_FIRST = 2'h0;
  localparam logic [1:0] TX_IDX_SECOND = 2'h1;
  typedef enum logic [1:0] {SFLCU_IDLE, SFLCU_SHIFT, SFLCU_SEND} sflcu_state_type;
endpackage

// ### hw/sflcu_top.sv
// serial frame LRC/CRC generator and checker
`timescale 1ns/1ps
`default_nettype none
module sflcu_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  input wire logic ascii_mode,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic check_valid,
  input wire logic [15:0] check_data,
  input wire logic send_req,
  output logic busy_r,
  output logic done_r,
  output logic [7:0] lrc_r,
  output logic [15:0] crc_r,
  output logic check_err_r,
  output logic check_done_r,
  output logic tx_valid_r,
  output logic [7:0] tx_byte_r,
  output logic tx_last_r
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] sflcu_hex(input logic [3:0] nib);
    logic [7:0] base;
    base = (nib > sflcu_pkg::NIB_NINE) ? sflcu_pkg::ASCII_A_LESS10 : sflcu_pkg::ASCII_ZERO;
    sflcu_hex = base + {4'h0, nib};
  endfunction

  function automatic logic [15:0] sflcu_step(input logic [15:0] r);
    sflcu_step = r[0] ? ((r >> 1) ^ sflcu_pkg::CRC_POLY) : (r >> 1);
  endfunction

  function automatic logic [7:0] sflcu_lrc(input logic [7:0] sum);
    sflcu_lrc = (sflcu_pkg::LRC_ONES - sum) + sflcu_pkg::LRC_ONE;
  endfunction

  // ****************************************
  // state and decode
  // ****************************************
  sflcu_pkg::sflcu_state_type state_r;
  sflcu_pkg::sflcu_state_type state_nxt;
  logic [2:0] shift_cnt_r;
  logic [2:0] shift_cnt_nxt;
  logic [7:0] lrc_sum_r;
  logic [7:0] lrc_sum_nxt;
  logic [7:0] lrc_nxt;
  logic [15:0] crc_mix;
  logic [15:0] crc_nxt;
  logic is_idle;
  logic is_shift;
  logic is_send;
  logic take_byte;
  logic take_check;
  logic take_send;
  logic is_delim;
  logic sum_byte;
  logic last_shift;
  logic check_mis;
  logic done_nxt;
  logic check_err_nxt;
  logic [7:0] tx_first;
  logic [7:0] tx_second;
  logic [7:0] tx_byte_nxt;

  assign is_idle = (state_r == sflcu_pkg::SFLCU_IDLE);
  assign is_shift = (state_r == sflcu_pkg::SFLCU_SHIFT);
  assign is_send = (state_r == sflcu_pkg::SFLCU_SEND);
  // priority in idle: clear, then a byte, then a check field, then a send request
  assign take_byte = is_idle && !clear && byte_valid;
  assign take_check = is_idle && !clear && !byte_valid && check_valid;
  assign take_send = is_idle && !clear && !byte_valid && !check_valid && send_req;
  assign is_delim = (byte_data == sflcu_pkg::ASCII_COLON) ||
    (byte_data == sflcu_pkg::ASCII_CR) ||
    (byte_data == sflcu_pkg::ASCII_LF);
  // frame delimiters stay out of the sum in ascii mode only
  assign sum_byte = take_byte && !(ascii_mode && is_delim);
  assign last_shift = is_shift && (shift_cnt_r == sflcu_pkg::SHIFT_LAST);

  // ****************************************
  // check arithmetic
  // ****************************************
  assign lrc_sum_nxt = clear ? sflcu_pkg::LRC_PRESET :
    (sum_byte ? lrc_sum_r + byte_data : lrc_sum_r);
  assign lrc_nxt = sflcu_lrc(lrc_sum_nxt);
  // only the eight data bits arrive here; framing bits never reach the unit
  assign crc_mix = {crc_r[15:8], crc_r[7:0] ^ byte_data};
  assign crc_nxt = clear ? sflcu_pkg::CRC_PRESET :
    take_byte ? crc_mix :
    is_shift ? sflcu_step(crc_r) :
    crc_r;
  assign check_mis = ascii_mode ? (check_data[7:0] != lrc_r) : (check_data != crc_r);
  assign check_err_nxt = clear ? 1'b0 : (take_check ? check_mis : check_err_r);
  assign done_nxt = (clear || take_byte) ? 1'b0 : (last_shift ? 1'b1 : done_r);
  assign tx_first = ascii_mode ? sflcu_hex(lrc_r[7:4]) : crc_r[7:0];
  assign tx_second = ascii_mode ? sflcu_hex(lrc_r[3:0]) : crc_r[15:8];
  assign tx_byte_nxt = take_send ? tx_first : (is_send ? tx_second : tx_byte_r);

  // ****************************************
  // sequencing
  // ****************************************
  // one shift step per cycle, eight cycles per byte
  always_comb begin
    state_nxt = state_r;
    shift_cnt_nxt = shift_cnt_r;
    case (state_r)
      sflcu_pkg::SFLCU_IDLE: begin
        if (take_byte) begin
          state_nxt = sflcu_pkg::SFLCU_SHIFT;
          shift_cnt_nxt = '0;
        end else if (take_send) begin
          state_nxt = sflcu_pkg::SFLCU_SEND;
        end
      end
      sflcu_pkg::SFLCU_SHIFT: begin
        shift_cnt_nxt = shift_cnt_r + 3'h1;
        if (clear || last_shift) begin
          state_nxt = sflcu_pkg::SFLCU_IDLE;
        end
      end
      sflcu_pkg::SFLCU_SEND: begin
        state_nxt = sflcu_pkg::SFLCU_IDLE;
      end
      default: begin
        state_nxt = sflcu_pkg::SFLCU_IDLE;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= sflcu_pkg::SFLCU_IDLE;
      shift_cnt_r <= '0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_cnt_r <= shift_cnt_nxt;
      busy_r <= (state_nxt != sflcu_pkg::SFLCU_IDLE);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      crc_r <= sflcu_pkg::CRC_PRESET;
      lrc_sum_r <= sflcu_pkg::LRC_PRESET;
      lrc_r <= sflcu_lrc(sflcu_pkg::LRC_PRESET);
    end else begin
      crc_r <= crc_nxt;
      lrc_sum_r <= lrc_sum_nxt;
      lrc_r <= lrc_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      done_r <= 1'b0;
      check_done_r <= 1'b0;
      check_err_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      check_done_r <= take_check;
      check_err_r <= check_err_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_valid_r <= 1'b0;
      tx_last_r <= 1'b0;
      tx_byte_r <= 8'h00;
    end else begin
      tx_valid_r <= take_send || is_send;
      tx_last_r <= is_send;
      tx_byte_r <= tx_byte_nxt;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_shifting;
    busy_r [*8];
  endsequence

  sequence s_settled;
    !busy_r && done_r;
  endsequence

  sequence s_tx_low;
    tx_valid_r && !tx_last_r && (tx_byte_r == $past(crc_r[7:0]));
  endsequence

  sequence s_tx_high;
    tx_valid_r && tx_last_r && (tx_byte_r == $past(crc_r[15:8], 2));
  endsequence

  sequence s_hex_high;
    tx_valid_r && !tx_last_r && (tx_byte_r == sflcu_hex($past(lrc_r[7:4])));
  endsequence

  sequence s_hex_low;
    tx_valid_r && tx_last_r && (tx_byte_r == sflcu_hex($past(lrc_r[3:0], 2)));
  endsequence

  property p_preset;
    @(posedge mclk) disable iff (rst)
    clear |=> (crc_r == sflcu_pkg::CRC_PRESET) && (lrc_sum_r == sflcu_pkg::LRC_PRESET) && !done_r;
  endproperty
  a_preset: assert property (p_preset) else $error("clear did not preset the check values");

  property p_xor_low;
    @(posedge mclk) disable iff (rst || clear)
    take_byte |=> crc_r == {$past(crc_r[15:8]), $past(crc_r[7:0]) ^ $past(byte_data)};
  endproperty
  a_xor_low: assert property (p_xor_low) else $error("byte not folded into low half");

  property p_shift_step;
    @(posedge mclk) disable iff (rst || clear)
    is_shift |=> crc_r == (($past(crc_r) >> 1) ^ ({16{$past(crc_r[0])}} & sflcu_pkg::CRC_POLY));
  endproperty
  a_shift_step: assert property (p_shift_step) else $error("wrong shift step");

  property p_byte_len;
    @(posedge mclk) disable iff (rst || clear)
    take_byte |=> s_shifting ##1 s_settled;
  endproperty
  a_byte_len: assert property (p_byte_len) else $error("byte not done after eight shifts");

  property p_lrc_sum;
    @(posedge mclk) disable iff (rst || clear)
    sum_byte |=> lrc_sum_r == 8'($past(lrc_sum_r) + $past(byte_data));
  endproperty
  a_lrc_sum: assert property (p_lrc_sum) else $error("sum did not wrap as an 8-bit add");

  property p_lrc_skip;
    @(posedge mclk) disable iff (rst || clear)
    take_byte && ascii_mode && is_delim |=> $stable(lrc_sum_r);
  endproperty
  a_lrc_skip: assert property (p_lrc_skip) else $error("delimiter entered the sum");

  property p_lrc_pair;
    @(posedge mclk) disable iff (rst)
    8'(lrc_sum_r + lrc_r) == 8'h00;
  endproperty
  a_lrc_pair: assert property (p_lrc_pair) else $error("check byte not the negated sum");

  property p_check;
    @(posedge mclk) disable iff (rst || clear)
    take_check |=> check_done_r && (check_err_r == ($past(ascii_mode) ?
      ($past(check_data[7:0]) != $past(lrc_r)) : ($past(check_data) != $past(crc_r))));
  endproperty
  a_check: assert property (p_check) else $error("wrong check verdict");

  property p_send_rtu;
    @(posedge mclk) disable iff (rst || clear)
    take_send && !ascii_mode |=> s_tx_low ##1 s_tx_high;
  endproperty
  a_send_rtu: assert property (p_send_rtu) else $error("cyclic check bytes out of order");

  property p_send_ascii;
    @(posedge mclk) disable iff (rst || clear)
    take_send && ascii_mode |=> s_hex_high ##1 s_hex_low;
  endproperty
  a_send_ascii: assert property (p_send_ascii) else $error("check characters out of order");
endmodule // sflcu_top
`default_nettype wire

// ### verif/sflcu_framer.sv
// framer model: clears, message bytes, received check fields and send requests
`timescale 1ns/1ps
`default_nettype none
module sflcu_framer (
  input wire logic mclk,
  input wire logic busy_r,
  output logic clear,
  output logic ascii_mode,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic check_valid,
  output logic [15:0] check_data,
  output logic send_req
);
  int seed = 26983;

  initial begin
    clear = 1'b0;
    ascii_mode = 1'b0;
    byte_valid = 1'b0;
    byte_data = 8'h00;
    check_valid = 1'b0;
    check_data = 16'h0000;
    send_req = 1'b0;
  end

  // every strobe waits for an idle unit and lasts one cycle
  task automatic pulse_clear(input logic mode);
    @(posedge mclk iff !busy_r);
    clear <= 1'b1;
    ascii_mode <= mode;
    @(posedge mclk);
    clear <= 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] d);
    repeat ($unsigned($random(seed)) % 3) @(posedge mclk);
    @(posedge mclk iff !busy_r);
    byte_valid <= 1'b1;
    byte_data <= d;
    @(posedge mclk);
    byte_valid <= 1'b0;
    byte_data <= 8'($random(seed));
  endtask

  task automatic put_check(input logic [15:0] c);
    @(posedge mclk iff !busy_r);
    check_valid <= 1'b1;
    check_data <= c;
    @(posedge mclk);
    check_valid <= 1'b0;
    check_data <= 16'($random(seed));
  endtask

  task automatic put_send;
    @(posedge mclk iff !busy_r);
    send_req <= 1'b1;
    @(posedge mclk);
    send_req <= 1'b0;
  endtask
endmodule // sflcu_framer
`default_nettype wire

// ### verif/tb_top.sv
// bench for the check-value unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic clear;
  logic ascii_mode;
  logic byte_valid;
  logic [7:0] byte_data;
  logic check_valid;
  logic [15:0] check_data;
  logic send_req;
  logic busy_r;
  logic done_r;
  logic [7:0] lrc_r;
  logic [15:0] crc_r;
  logic check_err_r;
  logic check_done_r;
  logic tx_valid_r;
  logic [7:0] tx_byte_r;
  logic tx_last_r;
  logic done_prev = 1'b0;
  logic [23:0] val_q[$];
  logic err_q[$];
  logic [8:0] tx_q[$];
  logic [15:0] crc_m;
  logic [7:0] sum_m;
  logic mode_m;
  int failures = 0;
  int check_count = 0;
  int seed = 26983;
  int len;

  always #4 mclk = ~mclk;

  sflcu_framer fr_u (.mclk(mclk), .busy_r(busy_r), .clear(clear), .ascii_mode(ascii_mode),
    .byte_valid(byte_valid), .byte_data(byte_data), .check_valid(check_valid),
    .check_data(check_data), .send_req(send_req));
  sflcu_top dut_u (.mclk(mclk), .rst(rst), .clear(clear), .ascii_mode(ascii_mode),
    .byte_valid(byte_valid), .byte_data(byte_data), .check_valid(check_valid),
    .check_data(check_data), .send_req(send_req), .busy_r(busy_r), .done_r(done_r),
    .lrc_r(lrc_r), .crc_r(crc_r), .check_err_r(check_err_r), .check_done_r(check_done_r),
    .tx_valid_r(tx_valid_r), .tx_byte_r(tx_byte_r), .tx_last_r(tx_last_r));

  // reference model, straight from the check definitions
  function automatic logic [15:0] ref_crc(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = {c[15:8], c[7:0] ^ d};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ sflcu_pkg::CRC_POLY) : (r >> 1);
    return r;
  endfunction

  function automatic logic [7:0] ref_lrc(input logic [7:0] s);
    return 8'(8'hFF - s + 8'h01);
  endfunction

  function automatic logic [7:0] ref_hex(input logic [3:0] n);
    return (n > 4'h9) ? (8'h37 + {4'h0, n}) : (8'h30 + {4'h0, n});
  endfunction

  task automatic msg_start(input logic mode);
    mode_m = mode;
    crc_m = 16'hFFFF;
    sum_m = 8'h00;
    fr_u.pulse_clear(mode);
  endtask

  task automatic msg_byte(input logic [7:0] d);
    logic delim;
    delim = (d == sflcu_pkg::ASCII_COLON) || (d == sflcu_pkg::ASCII_CR) ||
      (d == sflcu_pkg::ASCII_LF);
    crc_m = ref_crc(crc_m, d);
    if (!(mode_m && delim)) sum_m = sum_m + d;
    val_q.push_back({ref_lrc(sum_m), crc_m});
    fr_u.put_byte(d);
  endtask

  task automatic msg_send;
    logic [7:0] l;
    l = ref_lrc(sum_m);
    tx_q.push_back({1'b0, mode_m ? ref_hex(l[7:4]) : crc_m[7:0]});
    tx_q.push_back({1'b1, mode_m ? ref_hex(l[3:0]) : crc_m[15:8]});
    fr_u.put_send();
  endtask

  task automatic msg_check(input logic [15:0] c);
    logic bad;
    bad = mode_m ? (c[7:0] != ref_lrc(sum_m)) : (c != crc_m);
    err_q.push_back(bad);
    fr_u.put_check(c);
  endtask

  task automatic cmp_val(input logic [23:0] act);
    logic [23:0] exp_v;
    exp_v = (val_q.size() > 0) ? val_q.pop_front() : 'x;
    check_count++;
    if (act !== exp_v) begin
      failures++;
      $display("unexpected value at %0t: got %h, expected %h", $time, act, exp_v);
    end
  endtask

  task automatic cmp_err(input logic act);
    logic exp_v;
    exp_v = (err_q.size() > 0) ? err_q.pop_front() : 1'bx;
    check_count++;
    if (act !== exp_v) begin
      failures++;
      $display("unexpected verdict at %0t: got %h, expected %h", $time, act, exp_v);
    end
  endtask

  task automatic cmp_tx(input logic [8:0] act);
    logic [8:0] exp_v;
    exp_v = (tx_q.size() > 0) ? tx_q.pop_front() : 'x;
    check_count++;
    if (act !== exp_v) begin
      failures++;
      $display("unexpected send byte at %0t: got %h, expected %h", $time, act, exp_v);
    end
  endtask

  task end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // scoreboard side: each result takes the oldest note of its kind
  always @(posedge mclk) begin
    done_prev <= done_r;
    if (!rst && done_r && !done_prev) cmp_val({lrc_r, crc_r});
    if (!rst && check_done_r) cmp_err(check_err_r);
    if (!rst && tx_valid_r) cmp_tx({tx_last_r, tx_byte_r});
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    msg_start(1'b0);
    msg_byte(8'h02);
    msg_byte(8'h07);
    msg_send();
    msg_check(16'h1241);
    msg_check(16'h4112);
    $display("rtu example test over");
    msg_start(1'b1);
    msg_byte(sflcu_pkg::ASCII_COLON);
    for (int i = 0; i < 6; i++) msg_byte(8'($random(seed)));
    msg_byte(sflcu_pkg::ASCII_CR);
    msg_byte(sflcu_pkg::ASCII_LF);
    msg_send();
    msg_check({8'h00, ref_lrc(sum_m)});
    msg_check({8'h00, ref_lrc(sum_m) ^ 8'h01});
    $display("ascii test over");
    for (int m = 0; m < 3; m++) begin
      msg_start(1'b0);
      len = 1 + int'($unsigned($random(seed)) % 6);
      for (int i = 0; i < len; i++) msg_byte(8'($random(seed)));
      msg_send();
      msg_check(crc_m);
      msg_check(crc_m ^ 16'h8000);
    end
    $display("random rtu test over");
    repeat (20) @(posedge mclk);
    if (val_q.size() + err_q.size() + tx_q.size() != 0) failures++;
    end_sim();
  end

  // watchdog: 5000 cycles, over ten times the expected run of at most some 370 cycles
  initial begin
    #40000;
    failures++;
    $display("watchdog expired");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
